// File: hdl/pwm_pkg.sv
// Package: register map, field layout, state encodings and timing for the block
package pwm_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_PMT = 8'h84;
   localparam logic [7:0] OFF_IRQ_STS = 8'h58;
   localparam logic [7:0] OFF_IRQ_EN = 8'h5C;
   localparam logic [7:0] OFF_PHY_IN = 8'h60;
   // Power control register fields
   localparam int PMT_MODE_LSB = 29;
   localparam int PMT_SLEEP_BIT = 28;
   localparam int PMT_LED_OFF_BIT = 12;
   localparam int PMT_FABRIC_OFF_BIT = 11;
   localparam int PMT_TIME_OFF_BIT = 10;
   localparam int PMT_STAMP_LSB = 7;
   localparam int PMT_WAKE_EN_A_BIT = 6;
   localparam int PMT_WAKE_EN_B_BIT = 5;
   localparam int PMT_WAKE_ST_A_BIT = 4;
   localparam int PMT_WAKE_ST_B_BIT = 3;
   localparam int PMT_AUTO_WAKE_BIT = 1;
   localparam int PMT_READY_BIT = 0;
   localparam int STAMP_UNITS = 3;
   // Interrupt status and enable fields
   localparam int IRQ_PHY_A_BIT = 26;
   localparam int IRQ_PHY_B_BIT = 27;
   localparam int IRQ_PWR_EVT_BIT = 17;
   // Power state encodings
   localparam logic [2:0] MODE_RUN = 3'h0;
   localparam logic [2:0] MODE_SYSCLK_OFF = 3'h1;
   localparam logic [2:0] MODE_PLL_OFF = 3'h2;
   localparam logic [2:0] MODE_FULL_OFF = 3'h3;
   // Timing
   localparam int CLK_HZ = 100_000_000;
   localparam int WAKE_US = 2000;
   localparam int PLL_SETTLE_US = 100;
   localparam int PLL_SETTLE_CYC = PLL_SETTLE_US * (CLK_HZ / 1_000_000);
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum {ST_RUN, ST_SLEEP, ST_SETTLE} pstate_t;

   // Clock and gating outputs grouped together
   typedef struct packed {
      logic xtal_on;
      logic pll_on;
      logic sysclk_on;
      logic netclk_on;
      logic fabric_clk_on;
      logic time_clk_on;
      logic [STAMP_UNITS-1:0] stamp_clk_on;
   } gates_t;
endpackage

// File: hdl/power_wake_manager.sv
// Power and wake manager: event latching, block and chip clock gating
//
// Overview of operation
// - PHY in energy-detect powerdown wakes on cable energy, sets energy flag
// - Carrier already present at powerdown enable reports energy at once
// - Unmasked PHY irq shows in status bits 26 and 27; enabled drives pin
// - Any PHY irq of a port sets that port's wake status bit
// - PHY detects four wake-on-LAN frame kinds and sets its wake flag
// - Port wake status bits latch and stay set after the event
// - Latched wake status ANDed with enables, ORed into power event status
// - Power event status gated by its enable, ORed onto irq pin
// - With auto wake set, power event wakes from auto-exit states
// - Disabling a block clock freezes it without resetting it
// - Fabric clock-off sets only after two consecutive 1 writes
// - Time unit clock-off uses the same two-write rule
// - Each stamp unit clock-off needs two consecutive 1 writes
// - Indicator-off: open-drain undriven, push-pull driven inactive
// - Register contents are kept through every power state
// - Every chip reset enters the normal run state, all clocks on
// - Sysclk-off state stops system clocks, keeps crystal, PLL, net clocks
// - PLL-off state stops PLL only when both PHYs are powered down
// - Full-off state stops everything; only manual host wake exits
// - Power state selection never enables wake detection by itself
// - State field codes 000 to 011; 100 to 111 reserved
// - Ready forced low on entry to any low power state
// - Wake returns to run, PLL settles, ready rises, mode fields clear
`timescale 1ns/1ps
module power_wake_manager (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic port_a_phy_irq_flag,
   input wire logic port_b_phy_irq_flag,
   input wire logic [1:0] phy_general_powerdown,
   input wire logic other_irq,
   input wire logic manual_wake,
   input wire logic [2:0] led_in,
   input wire logic [2:0] led_push_pull,
   output logic [2:0] led_out,
   output logic [2:0] led_oe,
   output logic irq,
   output pwm_pkg::gates_t gates
);
   ////////////////////////////////////////////////////////////////////////
   // Register and state storage
   logic [2:0] mode_q, mode_d;
   logic sleep_q, sleep_d;
   logic fab_off_q, fab_off_d, fab_arm_q, fab_arm_d;
   logic time_off_q, time_off_d, time_arm_q, time_arm_d;
   logic [pwm_pkg::STAMP_UNITS-1:0] st_off_q, st_off_d, st_arm_q, st_arm_d;
   logic led_off_q, led_off_d;
   logic en_a_q, en_a_d, en_b_q, en_b_d;
   logic wst_a_q, wst_a_d, wst_b_q, wst_b_d;
   logic auto_q, auto_d;
   logic ready_q, ready_d;
   logic [1:0] phy_en_q, phy_en_d;
   logic pwr_en_q, pwr_en_d;
   pwm_pkg::pstate_t ps_q, ps_d;
   logic [2:0] cur_mode_q, cur_mode_d;
   logic [15:0] cnt_q, cnt_d;
   // Bus storage
   logic aw_q, aw_d, w_q, w_d;
   logic [7:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d;
   logic [3:0] ws_q, ws_d;
   logic bv_q, bv_d, rv_q, rv_d;
   logic [1:0] br_q, br_d, rr_q, rr_d;
   logic [31:0] rd_q, rd_d;
   logic irq_q, irq_d;
   logic awr_q, wrr_q, arr_q;
   logic [2:0] lo_q, lo_d, loe_q, loe_d;
   pwm_pkg::gates_t g_q, g_d;

   logic pwr_evt;
   logic wr_go, wr_pmt, wr_en;
   logic [31:0] pmt_rd, sts_rd;

   ////////////////////////////////////////////////////////////////////////
   // Combined event view, not a stored bit
   assign pwr_evt = (wst_a_q & en_a_q) | (wst_b_q & en_b_q);

   // Read images of the two main registers
   always_comb begin
      pmt_rd = '0;
      pmt_rd[pwm_pkg::PMT_MODE_LSB +: 3] = mode_q;
      pmt_rd[pwm_pkg::PMT_SLEEP_BIT] = sleep_q;
      pmt_rd[pwm_pkg::PMT_LED_OFF_BIT] = led_off_q;
      pmt_rd[pwm_pkg::PMT_FABRIC_OFF_BIT] = fab_off_q;
      pmt_rd[pwm_pkg::PMT_TIME_OFF_BIT] = time_off_q;
      pmt_rd[pwm_pkg::PMT_STAMP_LSB +: pwm_pkg::STAMP_UNITS] = st_off_q;
      pmt_rd[pwm_pkg::PMT_WAKE_EN_A_BIT] = en_a_q;
      pmt_rd[pwm_pkg::PMT_WAKE_EN_B_BIT] = en_b_q;
      pmt_rd[pwm_pkg::PMT_WAKE_ST_A_BIT] = wst_a_q;
      pmt_rd[pwm_pkg::PMT_WAKE_ST_B_BIT] = wst_b_q;
      pmt_rd[pwm_pkg::PMT_AUTO_WAKE_BIT] = auto_q;
      pmt_rd[pwm_pkg::PMT_READY_BIT] = ready_q;
      sts_rd = '0;
      sts_rd[pwm_pkg::IRQ_PHY_A_BIT] = port_a_phy_irq_flag;
      sts_rd[pwm_pkg::IRQ_PHY_B_BIT] = port_b_phy_irq_flag;
      sts_rd[pwm_pkg::IRQ_PWR_EVT_BIT] = pwr_evt;
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave: address and data taken in either order
   assign wr_go = aw_q & w_q & ~bv_q;
   assign wr_pmt = wr_go & (awa_q[7:2] == pwm_pkg::OFF_PMT[7:2]) & ws_q[3];
   assign wr_en = wr_go & (awa_q[7:2] == pwm_pkg::OFF_IRQ_EN[7:2]);

   always_comb begin
      aw_d = aw_q;
      w_d = w_q;
      awa_d = awa_q;
      wd_d = wd_q;
      ws_d = ws_q;
      bv_d = bv_q;
      br_d = br_q;
      rv_d = rv_q;
      rr_d = rr_q;
      rd_d = rd_q;
      if (s_axi_awvalid && !aw_q) begin
         aw_d = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q) begin
         w_d = 1'b1;
         wd_d = s_axi_wdata;
         ws_d = s_axi_wstrb;
      end
      if (wr_go) begin
         aw_d = 1'b0;
         w_d = 1'b0;
         bv_d = 1'b1;
         unique case (awa_q[7:2])
            pwm_pkg::OFF_PMT[7:2], pwm_pkg::OFF_IRQ_EN[7:2],
            pwm_pkg::OFF_IRQ_STS[7:2], pwm_pkg::OFF_PHY_IN[7:2]:
               br_d = pwm_pkg::RESP_OKAY;
            default: br_d = pwm_pkg::RESP_SLVERR;
         endcase
      end
      if (bv_q && s_axi_bready) begin
         bv_d = 1'b0;
      end
      if (s_axi_arvalid && !rv_q) begin
         rv_d = 1'b1;
         rr_d = pwm_pkg::RESP_OKAY;
         unique case (s_axi_araddr[7:2])
            pwm_pkg::OFF_PMT[7:2]: rd_d = pmt_rd;
            pwm_pkg::OFF_IRQ_STS[7:2]: rd_d = sts_rd;
            pwm_pkg::OFF_IRQ_EN[7:2]: begin
               rd_d = '0;
               rd_d[pwm_pkg::IRQ_PHY_A_BIT] = phy_en_q[0];
               rd_d[pwm_pkg::IRQ_PHY_B_BIT] = phy_en_q[1];
               rd_d[pwm_pkg::IRQ_PWR_EVT_BIT] = pwr_en_q;
            end
            pwm_pkg::OFF_PHY_IN[7:2]: rd_d = {30'h0, phy_general_powerdown};
            default: begin
               rd_d = '0;
               rr_d = pwm_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register next values and power sequencing
   always_comb begin
      mode_d = mode_q;
      sleep_d = sleep_q;
      fab_off_d = fab_off_q;
      fab_arm_d = fab_arm_q;
      time_off_d = time_off_q;
      time_arm_d = time_arm_q;
      st_off_d = st_off_q;
      st_arm_d = st_arm_q;
      led_off_d = led_off_q;
      en_a_d = en_a_q;
      en_b_d = en_b_q;
      auto_d = auto_q;
      ready_d = ready_q;
      phy_en_d = phy_en_q;
      pwr_en_d = pwr_en_q;
      ps_d = ps_q;
      cur_mode_d = cur_mode_q;
      cnt_d = cnt_q;
      // Status clears by writing one; a new event in that cycle wins
      wst_a_d = wst_a_q;
      wst_b_d = wst_b_q;
      if (wr_pmt && ws_q[0]) begin
         if (wd_q[pwm_pkg::PMT_WAKE_ST_A_BIT]) wst_a_d = 1'b0;
         if (wd_q[pwm_pkg::PMT_WAKE_ST_B_BIT]) wst_b_d = 1'b0;
      end
      if (port_a_phy_irq_flag) wst_a_d = 1'b1;
      if (port_b_phy_irq_flag) wst_b_d = 1'b1;
      if (wr_en) begin
         phy_en_d[0] = wd_q[pwm_pkg::IRQ_PHY_A_BIT];
         phy_en_d[1] = wd_q[pwm_pkg::IRQ_PHY_B_BIT];
         pwr_en_d = wd_q[pwm_pkg::IRQ_PWR_EVT_BIT];
      end
      if (wr_pmt) begin
         // Mode ignored when sleep written with one in same write
         if (wd_q[pwm_pkg::PMT_SLEEP_BIT]) begin
            if (ps_q == pwm_pkg::ST_RUN && mode_q != pwm_pkg::MODE_RUN &&
                !mode_q[2]) begin
               sleep_d = 1'b1;
            end
         end else begin
            mode_d = wd_q[pwm_pkg::PMT_MODE_LSB +: 3];
         end
         // Two writes of one arm then set; a zero disarms
         fab_arm_d = wd_q[pwm_pkg::PMT_FABRIC_OFF_BIT];
         if (wd_q[pwm_pkg::PMT_FABRIC_OFF_BIT] && fab_arm_q) fab_off_d = 1'b1;
         if (!wd_q[pwm_pkg::PMT_FABRIC_OFF_BIT]) fab_off_d = 1'b0;
         time_arm_d = wd_q[pwm_pkg::PMT_TIME_OFF_BIT];
         if (wd_q[pwm_pkg::PMT_TIME_OFF_BIT] && time_arm_q) time_off_d = 1'b1;
         if (!wd_q[pwm_pkg::PMT_TIME_OFF_BIT]) time_off_d = 1'b0;
         for (int i = 0; i < pwm_pkg::STAMP_UNITS; i++) begin
            st_arm_d[i] = wd_q[pwm_pkg::PMT_STAMP_LSB + i];
            if (wd_q[pwm_pkg::PMT_STAMP_LSB + i] && st_arm_q[i])
               st_off_d[i] = 1'b1;
            if (!wd_q[pwm_pkg::PMT_STAMP_LSB + i]) st_off_d[i] = 1'b0;
         end
         led_off_d = wd_q[pwm_pkg::PMT_LED_OFF_BIT];
         en_a_d = wd_q[pwm_pkg::PMT_WAKE_EN_A_BIT];
         en_b_d = wd_q[pwm_pkg::PMT_WAKE_EN_B_BIT];
         auto_d = wd_q[pwm_pkg::PMT_AUTO_WAKE_BIT];
      end
      // Sequencer: state, current mode, counter, sleep, mode and ready change here
      unique case (ps_q)
         pwm_pkg::ST_RUN: begin
            if (sleep_q) begin
               ps_d = pwm_pkg::ST_SLEEP;
               cur_mode_d = mode_q;
               ready_d = 1'b0;
            end
         end
         pwm_pkg::ST_SLEEP: begin
            if (manual_wake || (auto_q && pwr_evt &&
                cur_mode_q != pwm_pkg::MODE_FULL_OFF)) begin
               ps_d = pwm_pkg::ST_SETTLE;
               cnt_d = 16'(pwm_pkg::PLL_SETTLE_CYC);
            end
         end
         pwm_pkg::ST_SETTLE: begin
            if (cnt_q == 16'h0001) begin
               ps_d = pwm_pkg::ST_RUN;
               ready_d = 1'b1;
               mode_d = pwm_pkg::MODE_RUN;
               sleep_d = 1'b0;
               cur_mode_d = pwm_pkg::MODE_RUN;
            end
            cnt_d = cnt_q - 16'h0001;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Output images, all registered
   always_comb begin
      irq_d = (pwr_evt & pwr_en_q) | (port_a_phy_irq_flag & phy_en_q[0]) |
              (port_b_phy_irq_flag & phy_en_q[1]) | other_irq;
      g_d.xtal_on = (cur_mode_q != pwm_pkg::MODE_FULL_OFF);
      g_d.pll_on = !((cur_mode_q == pwm_pkg::MODE_PLL_OFF &&
                      &phy_general_powerdown) ||
                     cur_mode_q == pwm_pkg::MODE_FULL_OFF);
      g_d.sysclk_on = (cur_mode_q == pwm_pkg::MODE_RUN);
      g_d.netclk_on = (cur_mode_q != pwm_pkg::MODE_FULL_OFF);
      // Clock gating only; the blocks keep their state
      g_d.fabric_clk_on = g_d.sysclk_on & ~fab_off_q;
      g_d.time_clk_on = g_d.sysclk_on & ~time_off_q;
      g_d.stamp_clk_on = {pwm_pkg::STAMP_UNITS{g_d.time_clk_on}} & ~st_off_q;
      // Push-pull pins driven inactive, open pins released
      lo_d = led_off_q ? 3'h0 : led_in;
      loe_d = led_off_q ? led_push_pull : 3'h7;
   end

   ////////////////////////////////////////////////////////////////////////
   // All state registers; reset lands in the run state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_q <= pwm_pkg::MODE_RUN;
         cur_mode_q <= pwm_pkg::MODE_RUN;
         ps_q <= pwm_pkg::ST_RUN;
         ready_q <= 1'b1;
         br_q <= pwm_pkg::RESP_OKAY;
         rr_q <= pwm_pkg::RESP_OKAY;
         g_q <= '1;
         {awr_q, wrr_q, arr_q} <= '1;
         {sleep_q, fab_off_q, fab_arm_q, time_off_q, time_arm_q} <= '0;
         {st_off_q, st_arm_q, led_off_q, en_a_q, en_b_q} <= '0;
         {wst_a_q, wst_b_q, auto_q, phy_en_q, pwr_en_q, cnt_q} <= '0;
         {aw_q, w_q, awa_q, wd_q, ws_q, bv_q, rv_q, rd_q} <= '0;
         {irq_q, lo_q, loe_q} <= '0;
      end else if (ce) begin
         ps_q <= ps_d;
         {mode_q, cur_mode_q, ready_q, sleep_q, cnt_q} <=
            {mode_d, cur_mode_d, ready_d, sleep_d, cnt_d};
         {fab_off_q, fab_arm_q, time_off_q, time_arm_q} <=
            {fab_off_d, fab_arm_d, time_off_d, time_arm_d};
         {st_off_q, st_arm_q, led_off_q, en_a_q, en_b_q} <=
            {st_off_d, st_arm_d, led_off_d, en_a_d, en_b_d};
         {wst_a_q, wst_b_q, auto_q, phy_en_q, pwr_en_q} <=
            {wst_a_d, wst_b_d, auto_d, phy_en_d, pwr_en_d};
         {aw_q, w_q, awa_q, wd_q, ws_q} <= {aw_d, w_d, awa_d, wd_d, ws_d};
         {bv_q, br_q, rv_q, rr_q, rd_q} <= {bv_d, br_d, rv_d, rr_d, rd_d};
         {irq_q, lo_q, loe_q, g_q} <= {irq_d, lo_d, loe_d, g_d};
         // Ready flags kept in flops so the bus pins leave a register
         {awr_q, wrr_q, arr_q} <= ~{aw_d, w_d, rv_d};
      end
   end

   assign s_axi_awready = awr_q;
   assign s_axi_wready = wrr_q;
   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = br_q;
   assign s_axi_arready = arr_q;
   assign s_axi_rvalid = rv_q;
   assign s_axi_rresp = rr_q;
   assign s_axi_rdata = rd_q;
   assign irq = irq_q;
   assign led_out = lo_q;
   assign led_oe = loe_q;
   assign gates = g_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   // Second write of one in a row; the arm flag holds the first
   sequence fab_second_s;
      ce && wr_pmt && wd_q[pwm_pkg::PMT_FABRIC_OFF_BIT] && fab_arm_q;
   endsequence
   fab_two_a: assert property (@(posedge aclk)
      disable iff (!aresetn) fab_second_s |=> fab_off_q)
      else $error("fabric off not set on second write");
   wake_latch_a: assert property (@(posedge aclk)
      disable iff (!aresetn) ce && port_a_phy_irq_flag |=> wst_a_q)
      else $error("port a wake status not latched");
   fab_single_a: assert property (@(posedge aclk)
      disable iff (!aresetn) ce && wr_pmt && !fab_arm_q && !fab_off_q &&
      wd_q[pwm_pkg::PMT_FABRIC_OFF_BIT] |=> !fab_off_q)
      else $error("fabric off set by one write");
   fab_zero_a: assert property (@(posedge aclk)
      disable iff (!aresetn) ce && wr_pmt &&
      !wd_q[pwm_pkg::PMT_FABRIC_OFF_BIT] |=> !fab_arm_q && !fab_off_q)
      else $error("zero write did not disarm fabric");
   time_two_a: assert property (@(posedge aclk)
      disable iff (!aresetn) ce && wr_pmt && time_arm_q &&
      wd_q[pwm_pkg::PMT_TIME_OFF_BIT] |=> time_off_q)
      else $error("time unit off not set on second write");
   irq_gate_a: assert property (@(posedge aclk)
      disable iff (!aresetn) ce && pwr_evt && pwr_en_q |=> irq)
      else $error("enabled power event missing on irq");
   ready_low_a: assert property (@(posedge aclk)
      disable iff (!aresetn) ps_q == pwm_pkg::ST_SLEEP |-> !ready_q)
      else $error("ready high while asleep");
   full_off_a: assert property (@(posedge aclk)
      disable iff (!aresetn) ce && ps_q == pwm_pkg::ST_SLEEP &&
      !manual_wake && cur_mode_q == pwm_pkg::MODE_FULL_OFF
      |=> ps_q == pwm_pkg::ST_SLEEP)
      else $error("full off left without manual wake");
   sysclk_a: assert property (@(posedge aclk)
      disable iff (!aresetn) ce && cur_mode_q != pwm_pkg::MODE_RUN
      |=> !gates.sysclk_on)
      else $error("system clock running in low power");
   led_a: assert property (@(posedge aclk)
      disable iff (!aresetn) ce && led_off_q |=> led_out == 3'h0 &&
      led_oe == $past(led_push_pull))
      else $error("indicator pins not released");
endmodule

// File: tb/phy_pair_model.sv
// Behavioural model of the two PHYs feeding the wake inputs
`timescale 1ns/1ps
module phy_pair_model #(
   parameter int HOLD = 4
) (
   input wire logic aclk,
   input wire logic [1:0] ev,
   input wire logic [1:0] pd,
   output logic [1:0] flag,
   output logic [1:0] powerdown
);
   int cnt_q [2];
   ////////////////////////////////////////////////////////////////////////
   // Event stretcher: irq level stays up HOLD cycles, then drops
   always @(posedge aclk) begin
      for (int p = 0; p < 2; p++) begin
         if (ev[p]) begin
            cnt_q[p] <= HOLD;
         end else if (cnt_q[p] > 0) begin
            cnt_q[p] <= cnt_q[p] - 1;
         end
      end
   end
   // Levels come pre-masked to the one wake source the host unmasked
   assign flag[0] = (cnt_q[0] > 0);
   assign flag[1] = (cnt_q[1] > 0);
   assign powerdown = pd;
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the power and wake manager
`timescale 1ns/1ps
module tb_top;
   localparam logic [7:0] PM = pwm_pkg::OFF_PMT;
   localparam logic [7:0] IS = pwm_pkg::OFF_IRQ_STS;
   localparam logic [7:0] IE = pwm_pkg::OFF_IRQ_EN;
   logic aclk = 0, aresetn = 0, awv = 0, wvl = 0, brd = 0, arv = 0, rrd = 0;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wdt = 0, rdt;
   logic [1:0] brs, rrs, ev = 0, pdq = 0, fl, pdn;
   logic awr, wrd, bvl, arr, rvl, other_irq = 0, manual_wake = 0, irq;
   logic [2:0] led_in = 0, led_pp = 0, led_out, led_oe;
   pwm_pkg::gates_t gates;
   int n_fail = 0, samples_checked = 0;
   logic [31:0] d;
   logic [1:0] r;
   logic ce = 1;
   // Free-running 100 MHz clock
   always #5 aclk = ~aclk;
   ////////////////////////////////////////////////////////////////////////
   phy_pair_model phy_u (.aclk(aclk), .ev(ev), .pd(pdq), .flag(fl),
      .powerdown(pdn));
   power_wake_manager dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wdt), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvl),
      .s_axi_wready(wrd), .s_axi_bresp(brs), .s_axi_bvalid(bvl),
      .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rrs),
      .s_axi_rvalid(rvl), .s_axi_rready(rrd), .port_a_phy_irq_flag(fl[0]),
      .port_b_phy_irq_flag(fl[1]), .phy_general_powerdown(pdn),
      .other_irq(other_irq), .manual_wake(manual_wake), .led_in(led_in),
      .led_push_pull(led_pp), .led_out(led_out), .led_oe(led_oe),
      .irq(irq), .gates(gates));
   ////////////////////////////////////////////////////////////////////////
   task report_and_stop;
      $display("checks %0d errors %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      samples_checked++;
      if (s !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task tmo;
      n_fail++;
      $display("Error wait expected done seen timeout");
      report_and_stop;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // Write: address and data offered together, each dropped when taken
   task wr(input logic [7:0] a, input logic [31:0] v);
      int i;
      @(posedge aclk);
      awa <= a; wdt <= v; awv <= 1; wvl <= 1; brd <= 1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (awr) awv <= 0;
         if (wrd) wvl <= 0;
         if (bvl) break;
      end
      r = brs;
      brd <= 0;
      if (i == 50) tmo;
   endtask
   task rd(input logic [7:0] a);
      int i;
      @(posedge aclk);
      ara <= a; arv <= 1; rrd <= 1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (arr) arv <= 0;
         if (rvl) break;
      end
      d = rdt; r = rrs; rrd <= 0;
      if (i == 50) tmo;
   endtask
   task rc(input string n, input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
      rd(a);
      chk(n, e, d & m);
   endtask
   task pulse_a;
      @(posedge aclk) ev <= 2'h1;
      @(posedge aclk) ev <= 2'h0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_events;
      // Event while frozen must leave no trace
      @(posedge aclk) ce <= 0;
      pulse_a; cyc(8);
      @(posedge aclk) ce <= 1;
      rc("frozen", PM, 32'h10, 0);
      pulse_a; cyc(10);
      rc("stat_a", PM, 32'h10, 32'h10);
      rc("pe_off", IS, 32'h20000, 0);
      wr(PM, 32'h40);
      chk("wr_okay", pwm_pkg::RESP_OKAY, r);
      rc("pe_on", IS, 32'h20000, 32'h20000);
      chk("irq_masked", 0, irq);
      wr(IE, 32'h20000); cyc(2);
      chk("irq_pe", 1, irq);
      wr(PM, 32'h50); cyc(2);
      chk("irq_clr", 0, irq);
      @(posedge aclk) ev <= 2'h2;
      cyc(4);
      rc("phy_b", IS, 32'h0C000000, 32'h08000000);
      wr(IE, 32'h08000000); cyc(2);
      chk("irq_b", 1, irq);
      @(posedge aclk) ev <= 2'h0;
      wr(IE, 0); wr(PM, 32'h08);
      @(posedge aclk) other_irq <= 1;
      cyc(3);
      chk("irq_other", 1, irq);
      @(posedge aclk) other_irq <= 0;
   endtask
   // Each clock-off bit needs two back-to-back ones; a zero restarts it
   task t_clkoff;
      int b;
      logic [31:0] m, g;
      for (b = 7; b < 12; b++) begin
         m = 32'h1 << b;
         wr(PM, m);
         rc("off_once", PM, m, 0);
         wr(PM, 0); wr(PM, m);
         rc("cnt_reset", PM, m, 0);
         wr(PM, m);
         rc("off_twice", PM, m, m);
         // Time unit off also stops the stamp units inside it
         g = (b == 10) ? 32'h1F0 : 32'h1FF & ~(32'h1 << (b - 7));
         chk("gate_off", g, gates);
         wr(PM, 0); cyc(2);
         chk("gate_on", 32'h1FF, gates);
      end
   endtask
   task sl(input logic [2:0] m, input logic [31:0] x, input logic [3:0] g);
      wr(PM, {m, 29'h0} | x);
      wr(PM, {m, 29'h0} | x | 32'h10000000); cyc(4);
      chk("gates_sleep", g, gates[8:5]);
      rc("ready_low", PM, 32'h1, 0);
   endtask
   // Wake by host request or by the latched port event
   task wk(input bit man);
      int i;
      if (man) begin
         @(posedge aclk) manual_wake <= 1;
         @(posedge aclk) manual_wake <= 0;
      end else begin
         pulse_a;
      end
      cyc(50);
      rc("settling", PM, 32'h1, 0);
      for (i = 0; i < 6000 && !d[0]; i++) rd(PM);
      if (i == 6000) tmo;
      rc("woken", PM, 32'hF0000001, 32'h1);
      chk("gates_run", 32'h1FF, gates);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(3);
      aresetn <= 1;
      rc("pmt_rst", PM, 32'hFFFFFFFF, 32'h1);
      chk("gates_rst", 32'h1FF, gates);
      rd(8'h10);
      chk("unmapped", pwm_pkg::RESP_SLVERR, r);
      chk("unmapped_d", 0, d);
      wr(8'h10, 0);
      chk("wr_unmapped", pwm_pkg::RESP_SLVERR, r);
      t_events;
      t_clkoff;
      @(posedge aclk) begin led_in <= 3'h7; led_pp <= 3'h1; end
      wr(PM, 32'h1000); cyc(2);
      chk("led_oe", 32'h1, led_oe);
      chk("led_out", 0, led_out);
      wr(PM, 0);
      sl(3'h1, 0, 4'hD);
      rc("no_pe", IS, 32'h20000, 0);
      wk(1);
      @(posedge aclk) pdq <= 2'h1;
      sl(3'h2, 0, 4'hD);
      wk(1);
      @(posedge aclk) pdq <= 2'h3;
      rc("pd_in", pwm_pkg::OFF_PHY_IN, 32'h3, 32'h3);
      sl(3'h3, 32'h42, 4'h0);
      pulse_a; cyc(20);
      chk("full_off_stays", 0, gates[8:5]);
      wk(1);
      wr(PM, 32'h52);
      sl(3'h2, 32'h42, 4'h9);
      wk(0);
      report_and_stop;
   end
endmodule
